/* File: sfd_pkg.sv */
// Constants, state type and shared layout for the flow-through burst SRAM cycle decoder.
// Assumes one device clock; every user of this package imports it whole.

package sfd_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Geometry
	localparam int unsigned SFD_ADDR_W    = 19;   // Word address width, wide version
	localparam int unsigned SFD_LANES     = 4;    // Byte lanes, wide version
	localparam int unsigned SFD_LANES_NAR = 2;    // Byte lanes, narrow version
	localparam int unsigned SFD_BYTE_W    = 8;    // Data bits per lane
	localparam int unsigned SFD_LANE_W    = 9;    // Data plus parity per lane
	localparam int unsigned SFD_BURST_W   = 2;    // Burst counter covers the two low bits

	////////////////////////////////////////////////////////////////////////////////
	// Burst order and sleep timing
	localparam logic        SFD_MODE_LINEAR = 1'b0; // Low selects linear order
	localparam int unsigned SFD_SLEEP_CYC   = 2;    // Cycles to enter or leave sleep
	localparam logic [1:0]  SFD_SLEEP_LAST  = 2'(SFD_SLEEP_CYC - 1);

	////////////////////////////////////////////////////////////////////////////////
	// Operation in effect after an edge
	typedef enum logic [1:0] {
		SFD_ST_DESEL,
		SFD_ST_READ,
		SFD_ST_WRITE
	} sfd_state_t;

endpackage : sfd_pkg

/* File: sfd_burst_if.sv */
// Interface between the cycle decoder and its burst counter.
// Assumes both ends run on the same device clock.
`timescale 1ns/1ps

interface sfd_burst_if;
	logic       load;       // Load a new start address this edge
	logic       step;       // Advance the counter this edge
	logic [1:0] start_low;  // Low address bits presented with the load
	logic       mode;       // Burst order select
	logic [1:0] next_low;   // Low bits after one more step

	// Decoder side
	modport ctl (output load, output step, output start_low, output mode, input next_low);
	// Counter side
	modport ctr (input load, input step, input start_low, input mode, output next_low);
endinterface : sfd_burst_if

/* File: sfd_burst_ctr.sv */
// Two-bit burst counter with linear or interleaved order.
// Assumes the decoder pulses load and step at most one per clock, never both.
`timescale 1ns/1ps

module sfd_burst_ctr
	import sfd_pkg::*;
(
	// Clock and reset
	input  wire logic  ref_clk,
	input  wire logic  srst,
	// Decoder link
	sfd_burst_if.ctr   bif
);

	logic [1:0] start_ff;   // First address of the burst
	logic [1:0] cnt_ff;     // Steps taken since the load
	logic [1:0] cnt_plus;   // Count after one more step

	////////////////////////////////////////////////////////////////////////////////
	// Order function: both orders wrap after four beats
	function automatic logic [1:0] burst_order(input logic [1:0] s, input logic [1:0] c,
		input logic m);
		burst_order = (m == SFD_MODE_LINEAR) ? 2'(s + c) : (s ^ c);
	endfunction : burst_order

	assign cnt_plus     = 2'(cnt_ff + 2'h1);
	assign bif.next_low = burst_order(start_ff, cnt_plus, bif.mode);

	////////////////////////////////////////////////////////////////////////////////
	// Counter state; a load restarts the sequence
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			start_ff <= 2'h0;
			cnt_ff   <= 2'h0;
		end else if (bif.load) begin
			start_ff <= bif.start_low;
			cnt_ff   <= 2'h0;
		end else if (bif.step) begin
			cnt_ff   <= cnt_plus;
		end
	end

endmodule : sfd_burst_ctr

/* File: sfd_cycle_decode.sv */
// Cycle decoder and storage of a synchronous flow-through burst SRAM, shared data bus.
// Assumes the controller drives every synchronous input on ref_clk; only the sleep
// request arrives from outside that domain. Output enable is used without a clock.
`timescale 1ns/1ps

module sfd_cycle_decode
	import sfd_pkg::*;
#(
	parameter int unsigned ADDR_W = SFD_ADDR_W,  // Word address width
	parameter int unsigned LANES  = SFD_LANES    // Byte lanes, 4 or 2
) (
	// Clock and reset
	input  wire logic                          ref_clk,
	input  wire logic                          srst,
	// Address and chip selects
	input  wire logic [ADDR_W-1:0]             addr,
	input  wire logic                          chip_select_first_low_n,
	input  wire logic                          chip_select_second_high,
	input  wire logic                          chip_select_third_low_n,
	// Cycle control
	input  wire logic                          advance_or_load,
	input  wire logic                          write_enable_n,
	input  wire logic [LANES-1:0]              byte_lane_selects_n,
	input  wire logic                          clock_qualify_low_n,
	input  wire logic                          output_enable_n,
	input  wire logic                          burst_mode,
	input  wire logic                          sleep_request,
	// Data bus, split into input, output and enable
	input  wire logic [LANES*SFD_BYTE_W-1:0]   dq_in,
	input  wire logic [LANES-1:0]              parity_bits_in,
	output logic      [LANES*SFD_BYTE_W-1:0]   dq_out,
	output logic      [LANES-1:0]              parity_bits_out,
	output logic                               dq_oe,
	// Status
	output logic                               asleep
);

	localparam int unsigned WORD_W = LANES * SFD_LANE_W;  // Stored word width
	localparam int unsigned DEPTH  = 2 ** ADDR_W;         // Words in the array

	////////////////////////////////////////////////////////////////////////////////
	// Elaboration checks
	initial begin
		if (LANES != SFD_LANES && LANES != SFD_LANES_NAR) begin
			$error("sfd_cycle_decode: LANES must be 4 or 2");
		end
		if (ADDR_W < SFD_BURST_W) begin
			$error("sfd_cycle_decode: ADDR_W too small for the burst counter");
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Storage and state
	logic [WORD_W-1:0]           mem_ff [DEPTH];   // Array; flip-flops by index
	sfd_state_t                  state_ff;         // Operation in effect
	sfd_state_t                  nxt_state;        // Operation after this edge
	logic [ADDR_W-1:0]           addr_hi_ff;       // Loaded address, counter holds low bits
	logic                        rd_drive_ff;      // Read data valid for the bus
	logic [LANES*SFD_BYTE_W-1:0] dq_out_ff;        // Read data bytes
	logic [LANES-1:0]            par_out_ff;       // Read parity bits
	logic                        wp_ff;            // Write waiting for its data edge
	logic [ADDR_W-1:0]           wp_addr_ff;       // Address of that write
	logic [LANES-1:0]            wp_sel_n_ff;      // Lanes of that write, active low
	// Sleep synchroniser and timing
	logic                        slp_s1_ff;        // First stage, read by second only
	logic                        slp_s2_ff;        // Second stage
	logic                        slp_s3_ff;        // Third stage
	logic                        slp_lvl_ff;       // Filtered sleep request
	logic [1:0]                  slp_cnt_ff;       // Cycles the request has differed
	logic                        asleep_ff;        // Device in sleep

	////////////////////////////////////////////////////////////////////////////////
	// Lane merge: selected lanes take new data, the rest keep the old word
	function automatic logic [WORD_W-1:0] lane_merge(input logic [WORD_W-1:0] old_w,
		input logic [WORD_W-1:0] new_w, input logic [LANES-1:0] sel_n);
		lane_merge = old_w;
		for (int i = 0; i < LANES; i++) begin
			if (!sel_n[i]) begin
				lane_merge[i*SFD_LANE_W +: SFD_LANE_W] = new_w[i*SFD_LANE_W +: SFD_LANE_W];
			end
		end
	endfunction : lane_merge

	// Pack bus bytes and parity into the stored lane layout {parity, byte}
	function automatic logic [WORD_W-1:0] pack_word(input logic [LANES*SFD_BYTE_W-1:0] d,
		input logic [LANES-1:0] p);
		pack_word = '0;
		for (int i = 0; i < LANES; i++) begin
			pack_word[i*SFD_LANE_W +: SFD_LANE_W] = {p[i], d[i*SFD_BYTE_W +: SFD_BYTE_W]};
		end
	endfunction : pack_word

	////////////////////////////////////////////////////////////////////////////////
	// Cycle decode, all continuous
	sfd_burst_if bif ();

	wire         halt      = asleep_ff | slp_lvl_ff;
	wire         take      = ~clock_qualify_low_n & ~halt;
	wire         cs_all    = ~chip_select_first_low_n & chip_select_second_high
	                         & ~chip_select_third_low_n;
	wire         any_lane  = ~(&byte_lane_selects_n);
	wire         do_load   = take & ~advance_or_load;
	wire         do_adv    = take & advance_or_load;
	wire         ld_desel  = do_load & ~cs_all;
	wire         ld_read   = do_load & cs_all & write_enable_n;
	wire         ld_write  = do_load & cs_all & ~write_enable_n;
	wire         adv_read  = do_adv & (state_ff == SFD_ST_READ);
	wire         adv_write = do_adv & (state_ff == SFD_ST_WRITE);
	// A write with no lane selected moves nothing and queues nothing
	wire         wr_now    = (ld_write | adv_write) & any_lane;
	wire         rd_now    = ld_read | adv_read;
	// Address of the access taken this edge
	wire [ADDR_W-1:0] eff_addr = do_load ? addr
	                             : {addr_hi_ff[ADDR_W-1:SFD_BURST_W], bif.next_low};
	// Data edge of the queued write; it also commits on a load
	wire         wp_commit = take & wp_ff;
	wire [WORD_W-1:0] wr_word  = pack_word(dq_in, parity_bits_in);
	// Read data, with the write committing this edge forwarded into it
	wire [WORD_W-1:0] rd_raw   = mem_ff[eff_addr];
	wire [WORD_W-1:0] rd_word  = (wp_commit && wp_addr_ff == eff_addr)
	                             ? lane_merge(rd_raw, wr_word, wp_sel_n_ff) : rd_raw;

	assign bif.load      = do_load & cs_all;
	// Deselect continuation holds the counter still
	assign bif.step      = adv_read | adv_write;
	assign bif.start_low = addr[SFD_BURST_W-1:0];
	assign bif.mode      = burst_mode;

	sfd_burst_ctr u_burst (
		.ref_clk (ref_clk),
		.srst    (srst),
		.bif     (bif)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next operation; a stalled edge keeps the current one, a halted edge deselects
	always_comb begin
		nxt_state = state_ff;
		if (halt) begin
			nxt_state = SFD_ST_DESEL;           // Pending accesses are dropped
		end else if (ld_desel) begin
			nxt_state = SFD_ST_DESEL;
		end else if (ld_read) begin
			nxt_state = SFD_ST_READ;
		end else if (ld_write) begin
			nxt_state = SFD_ST_WRITE;           // Abort too, so its continuation counts
		end
	end

	// Operation register; starts deselected
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_ff <= SFD_ST_DESEL;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// High address bits of the burst
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			addr_hi_ff <= '0;
		end else if (bif.load) begin
			addr_hi_ff <= addr;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path: flow-through, data valid right after the edge
	always_ff @(posedge ref_clk) begin
		if (srst || halt) begin
			rd_drive_ff <= 1'b0;
		end else if (take) begin
			rd_drive_ff <= rd_now;              // Write or deselect releases
		end
	end

	// Read data word; only loads on a taken read
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			dq_out_ff  <= '0;
			par_out_ff <= '0;
		end else if (rd_now) begin
			for (int i = 0; i < LANES; i++) begin
				dq_out_ff[i*SFD_BYTE_W +: SFD_BYTE_W] <= rd_word[i*SFD_LANE_W +: SFD_BYTE_W];
				par_out_ff[i] <= rd_word[i*SFD_LANE_W + SFD_BYTE_W];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Write path: control at one edge, data at the next taken edge
	always_ff @(posedge ref_clk) begin
		if (srst || halt) begin
			wp_ff       <= 1'b0;
			wp_addr_ff  <= '0;
			wp_sel_n_ff <= '1;
		end else if (wr_now) begin
			wp_ff       <= 1'b1;
			wp_addr_ff  <= eff_addr;
			wp_sel_n_ff <= byte_lane_selects_n;
		end else if (take) begin
			wp_ff       <= 1'b0;                // Committed below this same edge
		end
	end

	// Array write; a stalled edge leaves the data waiting
	always_ff @(posedge ref_clk) begin
		if (wp_commit) begin
			mem_ff[wp_addr_ff] <= lane_merge(mem_ff[wp_addr_ff], wr_word, wp_sel_n_ff);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sleep: three stages, a change counts once the second and third agree
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			slp_s1_ff <= 1'b0;
			slp_s2_ff <= 1'b0;
			slp_s3_ff <= 1'b0;
		end else begin
			slp_s1_ff <= sleep_request;
			slp_s2_ff <= slp_s1_ff;
			slp_s3_ff <= slp_s2_ff;
		end
	end

	// Filtered request level
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			slp_lvl_ff <= 1'b0;
		end else if (slp_s2_ff == slp_s3_ff) begin
			slp_lvl_ff <= slp_s3_ff;
		end
	end

	// Entry and exit each take the fixed count of cycles
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			slp_cnt_ff <= 2'h0;
			asleep_ff  <= 1'b0;
		end else if (slp_lvl_ff == asleep_ff) begin
			slp_cnt_ff <= 2'h0;
		end else if (slp_cnt_ff == SFD_SLEEP_LAST) begin
			slp_cnt_ff <= 2'h0;
			asleep_ff  <= slp_lvl_ff;
		end else begin
			slp_cnt_ff <= 2'(slp_cnt_ff + 2'h1);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs; the enable stays combinational so output enable acts without a clock,
	// the trade being one gate after the flip-flop
	assign dq_out          = dq_out_ff;
	assign parity_bits_out = par_out_ff;
	assign dq_oe           = rd_drive_ff & ~output_enable_n;
	assign asleep          = asleep_ff;

endmodule : sfd_cycle_decode

/* File: sfd_cycle_checker.sv */
// Port-level assertions for the cycle decoder.
// Assumes one clock and a synchronous active-high reset; bound into every decoder.
`timescale 1ns/1ps

module sfd_cycle_checker #(
	parameter int unsigned LANES = 4  // Byte lanes
) (
	// Clock and reset
	input wire logic             ref_clk,
	input wire logic             srst,
	// Cycle control
	input wire logic             chip_select_first_low_n,
	input wire logic             chip_select_second_high,
	input wire logic             chip_select_third_low_n,
	input wire logic             advance_or_load,
	input wire logic             write_enable_n,
	input wire logic             clock_qualify_low_n,
	input wire logic             output_enable_n,
	input wire logic             sleep_request,
	// Outputs
	input wire logic [LANES*8-1:0] dq_out,
	input wire logic             dq_oe,
	input wire logic             asleep
);
	logic [3:0] quiet_ff;  // Edges since sleep was last requested
	wire        sel_all = !chip_select_first_low_n && chip_select_second_high
		&& !chip_select_third_low_n;
	// Edges near sleep are left alone: the request passes a synchroniser first
	wire        awake = !asleep && quiet_ff == 4'hf;
	wire        take  = awake && !clock_qualify_low_n;
	wire        load  = take && !advance_or_load;

	////////////////////////////////////////////////////////////////////////////////
	// Sleep distance counter, saturating
	always_ff @(posedge ref_clk) begin
		if (srst || sleep_request) quiet_ff <= 4'h0;
		else if (quiet_ff != 4'hf) quiet_ff <= quiet_ff + 4'h1;
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);

	////////////////////////////////////////////////////////////////////////////////
	// Properties
	a_reset_bus_idle: assert property (disable iff (1'b0) srst |=> !dq_oe && !asleep)
		else $error("bus driven after reset");
	a_oe_gates_drive: assert property (dq_oe |-> !output_enable_n)
		else $error("bus driven with output enable off");
	a_stall_holds: assert property (awake && clock_qualify_low_n |=> $stable(dq_out))
		else $error("stalled edge changed read data");
	a_desel_floats: assert property (load && !sel_all |=> !dq_oe)
		else $error("deselect left bus driven");
	a_write_floats: assert property (load && sel_all && !write_enable_n |=> !dq_oe)
		else $error("write left bus driven");
	a_read_drives: assert property (load && sel_all && write_enable_n
		|=> dq_oe == !output_enable_n)
		else $error("read start bus drive wrong");
	a_read_burst: assert property (load && sel_all && write_enable_n ##1 take && advance_or_load
		|=> dq_oe == !output_enable_n)
		else $error("read continuation bus drive wrong");
	a_desel_stays: assert property (load && !sel_all ##1 take && advance_or_load |=> !dq_oe)
		else $error("advance after deselect drove bus");
	a_sleep_enters: assert property ($rose(sleep_request) ##1 sleep_request[*7] |-> asleep)
		else $error("sleep not entered in time");
	a_sleep_floats: assert property (asleep |-> !dq_oe)
		else $error("bus driven in sleep");
endmodule : sfd_cycle_checker

bind sfd_cycle_decode sfd_cycle_checker #(.LANES(LANES)) i_sfd_cycle_checker (
	.ref_clk(ref_clk), .srst(srst), .chip_select_first_low_n(chip_select_first_low_n),
	.chip_select_second_high(chip_select_second_high),
	.chip_select_third_low_n(chip_select_third_low_n), .advance_or_load(advance_or_load),
	.write_enable_n(write_enable_n), .clock_qualify_low_n(clock_qualify_low_n),
	.output_enable_n(output_enable_n), .sleep_request(sleep_request), .dq_out(dq_out),
	.dq_oe(dq_oe), .asleep(asleep));

/* File: sfd_ctl_model.sv */
// Memory controller side of the shared data bus.
// Assumes the bench says when write data is due; otherwise the wire wanders.
`timescale 1ns/1ps

module sfd_ctl_model
	import sfd_pkg::*;
#(
	parameter int unsigned LANES = SFD_LANES  // Byte lanes
) (
	// Clock
	input wire logic                          ref_clk,
	// Bench requests
	input wire logic                          wr_drive,
	input wire logic [LANES*SFD_LANE_W-1:0]   wr_word,
	// Device side of the bus
	input wire logic                          dq_oe,
	input wire logic [LANES*SFD_BYTE_W-1:0]   dq_out,
	input wire logic [LANES-1:0]              parity_bits_out,
	output logic     [LANES*SFD_BYTE_W-1:0]   dq_in,
	output logic     [LANES-1:0]              parity_bits_in
);
	logic [LANES*SFD_LANE_W-1:0] last_ff = '0;  // Wire level at the last edge
	logic [LANES*SFD_LANE_W-1:0] wire_lv;       // Resolved bus level

	// An undriven bus shows the inverse of its last level, never a stale copy
	assign wire_lv = dq_oe ? {parity_bits_out, dq_out} : wr_drive ? wr_word : ~last_ff;
	assign {parity_bits_in, dq_in} = wire_lv;

	always @(posedge ref_clk) last_ff <= wire_lv;
endmodule : sfd_ctl_model

/* File: testbench.sv */
// Random and corner-case bench for the wide and narrow cycle decoders with a reference memory.
// Assumes the controller model owns the data bus whenever the device releases it.
`timescale 1ns/1ps

module testbench;
	import sfd_pkg::*;
	localparam int W = SFD_LANES*SFD_LANE_W;  // Word with parity
	logic clk = 1'b0, rst = 1'b1, s1 = 1'b1, s2 = 1'b0, s3 = 1'b1, adv = 1'b0, we = 1'b1;
	logic cq = 1'b0, oe = 1'b1, md = 1'b0, zz = 1'b0, wdrv = 1'b0, pv = 1'b0, oe_o, slp;
	logic [SFD_ADDR_W-1:0] a = '0, base = '0, pa;  // Address, burst base, pending address
	logic [3:0] ln = 4'hf, pl, pbo, pbi;           // Lanes now and pending
	logic [1:0] n = 2'h0;                          // Burst step count
	logic [31:0] dqo, dqi;
	logic [W-1:0] wd = '0, mem [int];              // Write data, reference memory
	logic [15:0] nar_dqo;                          // Narrow version read bytes
	logic [1:0] nar_pbo;                           // Narrow version read parity
	logic nar_oe, nar_slp;                         // Narrow version drive and sleep
	sfd_state_t st = SFD_ST_DESEL;                 // Expected operation
	int fail_count = 0, num_checks = 0;

	always #20 clk = ~clk;

	sfd_cycle_decode #(.ADDR_W(SFD_ADDR_W), .LANES(4)) i_sfd_cycle_decode (.ref_clk(clk),
		.srst(rst), .addr(a), .chip_select_first_low_n(s1), .chip_select_second_high(s2),
		.chip_select_third_low_n(s3), .advance_or_load(adv), .write_enable_n(we),
		.byte_lane_selects_n(ln), .clock_qualify_low_n(cq), .output_enable_n(oe),
		.burst_mode(md), .sleep_request(zz), .dq_in(dqi), .parity_bits_in(pbi),
		.dq_out(dqo), .parity_bits_out(pbo), .dq_oe(oe_o), .asleep(slp));
	// Narrow version shares the low two lanes of the bus; its upper address bit stays low
	sfd_cycle_decode #(.ADDR_W(SFD_ADDR_W+1), .LANES(SFD_LANES_NAR)) i_sfd_cycle_decode_nar (
		.ref_clk(clk), .srst(rst), .addr({1'b0, a}), .chip_select_first_low_n(s1),
		.chip_select_second_high(s2), .chip_select_third_low_n(s3), .advance_or_load(adv),
		.write_enable_n(we), .byte_lane_selects_n(ln[1:0]), .clock_qualify_low_n(cq),
		.output_enable_n(oe), .burst_mode(md), .sleep_request(zz), .dq_in(dqi[15:0]),
		.parity_bits_in(pbi[1:0]), .dq_out(nar_dqo), .parity_bits_out(nar_pbo),
		.dq_oe(nar_oe), .asleep(nar_slp));
	sfd_ctl_model #(.LANES(4)) i_sfd_ctl_model (.ref_clk(clk), .wr_drive(wdrv), .wr_word(wd),
		.dq_oe(oe_o), .dq_out(dqo), .parity_bits_out(pbo), .dq_in(dqi), .parity_bits_in(pbi));

	////////////////////////////////////////////////////////////////////////////////
	// Expectation helpers
	function automatic logic [SFD_ADDR_W-1:0] cur();
		return {base[SFD_ADDR_W-1:2], md ? base[1:0] ^ n : base[1:0] + n};
	endfunction : cur
	function automatic logic [W-1:0] merge(logic [W-1:0] o, d, logic [3:0] l);
		for (int i = 0; i < 4; i++) if (!l[i]) begin
			o[8*i+:8] = d[8*i+:8];
			o[32+i]   = d[32+i];
		end
		return o;
	endfunction : merge
	task automatic chk(input logic [W-1:0] seen, input logic [W-1:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : conclude

	////////////////////////////////////////////////////////////////////////////////
	// One bus cycle: check the last edge, drive this one, update the reference
	task automatic step(input logic v_adv, v_sel, v_we, input logic [3:0] v_ln,
		input logic [SFD_ADDR_W-1:0] v_a, input logic v_oe, v_cq);
		int k;
		@(negedge clk);
		chk(oe_o, st == SFD_ST_READ && !oe);
		if (st == SFD_ST_READ) chk({pbo, dqo}, mem[cur()]);
		chk(nar_oe, st == SFD_ST_READ && !oe);
		if (st == SFD_ST_READ) chk({nar_pbo, nar_dqo},
			{mem[cur()][33:32], mem[cur()][15:0]});
		k = $urandom % 3;
		{adv, we, ln, a, oe, cq} = {v_adv, v_we, v_ln, v_a, v_oe, v_cq};
		{s1, s2, s3} = {!v_sel && k == 0, !(!v_sel && k == 1), !v_sel && k == 2};
		wdrv = pv;
		wd   = W'({$urandom, $urandom});
		if (!v_cq) begin
			if (pv) mem[pa] = merge(mem[pa], wd, pl);
			pv = 1'b0;
			if (!v_adv) begin
				base = v_a;
				n    = 2'h0;
				st   = !v_sel ? SFD_ST_DESEL : v_we ? SFD_ST_READ : SFD_ST_WRITE;
			end else if (st != SFD_ST_DESEL) n++;
			if (st == SFD_ST_WRITE && v_ln != 4'hf) {pv, pa, pl} = {1'b1, cur(), v_ln};
		end
	endtask : step

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		void'($urandom(39346));
		repeat (12) @(posedge clk);
		@(negedge clk) rst = 1'b0;
		for (int i = 0; i < 16; i += 4) begin
			step(0, 1, 0, 4'h0, SFD_ADDR_W'(i), 1, 0);
			repeat (3) step(1, 1, 1, 4'h0, '0, 1, 0);
		end
		step(0, 1, 0, 4'h5, 7, 0, 0); // Write then read at once, lanes 1 and 3
		step(0, 1, 1, 4'hf, 7, 0, 0);
		step(1, 0, 0, 4'h0, 0, 0, 1);
		step(0, 1, 0, 4'hf, 2, 1, 0); // Aborted write start, then a burst from it
		step(1, 1, 1, 4'h9, 0, 0, 0);
		step(0, 1, 1, 4'h0, 2, 0, 0);
		$display("fill and corner cases done");
		for (int m = 0; m < 2; m++) begin
			// Deselect first, so no burst in flight sees its order change
			step(0, 0, 1, 4'h0, 0, 0, 0);
			@(negedge clk) md = 1'(m);
			repeat (250) step($urandom % 3 != 0, $urandom % 5 != 0, 1'($urandom), 4'($urandom),
				SFD_ADDR_W'($urandom % 16), $urandom % 3 == 0, $urandom % 4 == 0);
			$display("random mode %0d done", m);
		end
		step(0, 0, 1, 4'h0, 0, 0, 0);
		step(0, 0, 1, 4'h0, 0, 0, 1);
		@(negedge clk) zz = 1'b1;
		repeat (10) @(negedge clk);
		chk(slp, 1);
		chk(nar_slp, 1);
		chk(oe_o, 0);
		zz = 1'b0;
		repeat (10) @(negedge clk);
		chk(slp, 0);
		chk(nar_slp, 0);
		step(0, 1, 1, 4'h0, 3, 0, 0);
		step(0, 0, 1, 4'h0, 0, 0, 0);
		$display("sleep done");
		conclude();
	end

	// Watchdog
	initial begin
		#200000;
		fail_count++;
		conclude();
	end
endmodule : testbench
